// ==== ifd_decoder.v ====
// Instruction format decoder: splits each 16-bit word into the fields of
// its layout family and works out extension words, targets and counts.
// Assumes fetch and datapath share pclk; workspace values come with the word.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ifd_consts.vh"

module ifd_decoder (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Fetch side
	input wire instr_valid,
	input wire [15:0] instr_word,
	input wire [15:0] instr_addr,
	input wire [15:0] wr0_val,
	input wire [15:0] wr12_val,
	output wire instr_ready,
	// Execution side handshake
	output reg dec_valid,
	input wire dec_ready,
	// Decoded fields
	output reg [10:0] fmt,
	output reg illegal,
	output reg [10:0] op_field,
	output reg width_select,
	output reg [1:0] target_mode,
	output reg [3:0] target_reg_num,
	output reg [1:0] origin_mode,
	output reg [3:0] origin_reg_num,
	output reg [3:0] shifted_reg_num,
	output reg [1:0] ext_words,
	output reg ext_origin,
	output reg ext_target,
	output reg [1:0] origin_step,
	output reg [1:0] target_step,
	output reg [15:0] jump_target,
	output reg [11:0] line_addr,
	output reg [4:0] tally,
	output reg tally_byte,
	output reg lines_load,
	output reg [4:0] shift_count,
	output reg [3:0] xop_num,
	output reg ctx_reload,
	output wire [3:0] ctx_wp_reg,
	output wire [3:0] ctx_pc_reg,
	output wire [3:0] ctx_flag_reg
);

	// Memory mode means an extension word follows
	function ext_of;
		input [1:0] mode;
		begin
			ext_of = (mode == `IFD_MODE_MEM);
		end
	endfunction

	// Auto-increment step; zero for other modes
	function [1:0] step_of;
		input [1:0] mode;
		input is_byte;
		begin
			if (mode != `IFD_MODE_AUTO) begin
				step_of = 2'h0;
			end else if (is_byte) begin
				step_of = `IFD_STEP_BYTE;
			end else begin
				step_of = `IFD_STEP_WORD;
			end
		end
	endfunction

	reg ctrl_en_q;
	reg [15:0] ill_cnt_q;
	reg [15:0] last_word_q;
	reg [15:0] last_addr_q;

	reg [10:0] f_d;
	reg ill_d;
	reg [10:0] op_d;
	reg wsel_d;
	reg [1:0] tm_d;
	reg [3:0] tr_d;
	reg [1:0] om_d;
	reg [3:0] or_d;
	reg [3:0] sr_d;
	reg [1:0] ext_d;
	reg eo_d;
	reg et_d;
	reg [1:0] os_d;
	reg [1:0] ts_d;
	reg [15:0] jt_d;
	reg [11:0] la_d;
	reg [4:0] tal_d;
	reg tb_d;
	reg ll_d;
	reg [4:0] sc_d;
	reg [3:0] xn_d;
	reg ctx_d;

	wire [15:0] iw = instr_word;
	wire [7:0] op8 = iw[15:8];
	wire [5:0] op6 = iw[15:10];
	wire [10:0] op11 = iw[15:5];
	// Word displacement sign-extended, scaled to bytes
	wire [15:0] disp_bytes = {{7{iw[7]}}, iw[7:0], 1'b0};
	wire [11:0] disp_bits = {{4{iw[7]}}, iw[7:0]};
	wire take = instr_valid & instr_ready;

	assign ctx_wp_reg = `IFD_CTX_WP_REG;
	assign ctx_pc_reg = `IFD_CTX_PC_REG;
	assign ctx_flag_reg = `IFD_CTX_FLAG_REG;

	// Stalls while the execution side still holds the previous result
	assign instr_ready = ctrl_en_q & (~dec_valid | dec_ready);

	always @* begin
		f_d = 11'h000;
		ill_d = 1'b0;
		op_d = 11'h000;
		wsel_d = 1'b0;
		tm_d = `IFD_MODE_DIRECT;
		tr_d = 4'h0;
		om_d = `IFD_MODE_DIRECT;
		or_d = 4'h0;
		sr_d = 4'h0;
		eo_d = 1'b0;
		et_d = 1'b0;
		ext_d = 2'h0;
		os_d = 2'h0;
		ts_d = 2'h0;
		jt_d = 16'h0000;
		la_d = 12'h000;
		tal_d = 5'h00;
		tb_d = 1'b0;
		ll_d = 1'b0;
		sc_d = 5'h00;
		xn_d = 4'h0;
		ctx_d = 1'b0;
		if (iw[15:13] >= 3'h2) begin
			f_d[`IFD_F_TWO] = 1'b1;
			op_d = {8'h00, iw[15:13]};
			wsel_d = iw[12];
			tm_d = iw[11:10];
			tr_d = iw[9:6];
			om_d = iw[5:4];
			or_d = iw[3:0];
			eo_d = ext_of(iw[5:4]);
			et_d = ext_of(iw[11:10]);
			ext_d = {1'b0, eo_d} + {1'b0, et_d};
			os_d = step_of(iw[5:4], iw[12]);
			ts_d = step_of(iw[11:10], iw[12]);
		end else if (iw[15:13] == 3'h1) begin
			op_d = {5'h00, op6};
			om_d = iw[5:4];
			or_d = iw[3:0];
			eo_d = ext_of(iw[5:4]);
			ext_d = {1'b0, eo_d};
			if (op6 == `IFD_OP_XOP) begin
				f_d[`IFD_F_XOP] = 1'b1;
				xn_d = iw[9:6];
				os_d = step_of(iw[5:4], 1'b0);
			end else if (op6 == `IFD_OP_LOAD_LINES || op6 == `IFD_OP_STORE_LINES) begin
				f_d[`IFD_F_MULTI] = 1'b1;
				tal_d = (iw[9:6] == 4'h0) ? `IFD_FULL_COUNT : {1'b0, iw[9:6]};
				tb_d = (tal_d <= `IFD_BYTE_MAX);
				os_d = step_of(iw[5:4], tb_d);
				la_d = wr12_val[12:1];
				ll_d = (op6 == `IFD_OP_LOAD_LINES);
			end else begin
				// Multiply and divide share this register-target layout
				f_d[`IFD_F_LOGIC] = 1'b1;
				tr_d = iw[9:6];
				os_d = step_of(iw[5:4], 1'b0);
			end
		end else if (op8 >= `IFD_OP_JUMP_LO) begin
			op_d = {3'h0, op8};
			if (op8 <= `IFD_OP_JUMP_HI) begin
				f_d[`IFD_F_JUMP] = 1'b1;
				// Sign extension keeps the reach at -128..+127 words
				jt_d = instr_addr + `IFD_PC_STEP + disp_bytes;
			end else begin
				f_d[`IFD_F_BIT] = 1'b1;
				la_d = wr12_val[12:1] + disp_bits;
			end
		end else if (op6 == 6'h02) begin
			f_d[`IFD_F_SHIFT] = 1'b1;
			op_d = {3'h0, op8};
			sr_d = iw[3:0];
			if (iw[7:4] != 4'h0) begin
				sc_d = {1'b0, iw[7:4]};
			end else if (wr0_val[3:0] != 4'h0) begin
				sc_d = {1'b0, wr0_val[3:0]};
			end else begin
				sc_d = `IFD_FULL_COUNT;
			end
		end else if (op6 == 6'h01) begin
			f_d[`IFD_F_SINGLE] = 1'b1;
			op_d = {1'b0, iw[15:6]};
			om_d = iw[5:4];
			or_d = iw[3:0];
			eo_d = ext_of(iw[5:4]);
			ext_d = {1'b0, eo_d};
			os_d = step_of(iw[5:4], 1'b0);
		end else if (op11 >= `IFD_OP_CTRL_LO && op11 <= `IFD_OP_CTRL_HI) begin
			op_d = op11;
			if (iw[4:0] == 5'h00) begin
				f_d[`IFD_F_CTRL] = 1'b1;
				ctx_d = (op11 == `IFD_OP_RET_CTX);
			end else begin
				ill_d = 1'b1;
			end
		end else if (op11 >= `IFD_OP_IMM_LO && op11 <= `IFD_OP_IMM_HI) begin
			op_d = op11;
			tr_d = iw[3:0];
			// Register-less forms must carry a zero register field
			if (iw[4] || ((op11 == `IFD_OP_LWPI || op11 == `IFD_OP_LIMI) && iw[3:0] != 4'h0)) begin
				ill_d = 1'b1;
			end else begin
				f_d[`IFD_F_IMM] = 1'b1;
				if (op11 != `IFD_OP_STWP && op11 != `IFD_OP_STST) begin
					ext_d = 2'h1;
				end
			end
		end else begin
			ill_d = 1'b1;
		end
		if (ill_d) begin
			f_d = 11'h000;
			op_d = 11'h000;
			tr_d = 4'h0;
			ext_d = 2'h0;
			eo_d = 1'b0;
			et_d = 1'b0;
		end
		f_d[`IFD_F_WIDTH] = wsel_d;
	end

	// Result registers hold until the execution side takes them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_valid <= 1'b0;
			fmt <= 11'h000;
			illegal <= 1'b0;
			op_field <= 11'h000;
			width_select <= 1'b0;
			target_mode <= 2'h0;
			target_reg_num <= 4'h0;
			origin_mode <= 2'h0;
			origin_reg_num <= 4'h0;
			shifted_reg_num <= 4'h0;
			ext_words <= 2'h0;
			ext_origin <= 1'b0;
			ext_target <= 1'b0;
			origin_step <= 2'h0;
			target_step <= 2'h0;
			jump_target <= 16'h0000;
			line_addr <= 12'h000;
			tally <= 5'h00;
			tally_byte <= 1'b0;
			lines_load <= 1'b0;
			shift_count <= 5'h00;
			xop_num <= 4'h0;
			ctx_reload <= 1'b0;
			last_word_q <= 16'h0000;
			last_addr_q <= 16'h0000;
		end else begin
			if (take) begin
				dec_valid <= 1'b1;
				fmt <= f_d;
				illegal <= ill_d;
				op_field <= op_d;
				width_select <= wsel_d;
				target_mode <= tm_d;
				target_reg_num <= tr_d;
				origin_mode <= om_d;
				origin_reg_num <= or_d;
				shifted_reg_num <= sr_d;
				ext_words <= ext_d;
				ext_origin <= eo_d;
				ext_target <= et_d;
				origin_step <= os_d;
				target_step <= ts_d;
				jump_target <= jt_d;
				line_addr <= la_d;
				tally <= tal_d;
				tally_byte <= tb_d;
				lines_load <= ll_d;
				shift_count <= sc_d;
				xop_num <= xn_d;
				ctx_reload <= ctx_d;
				last_word_q <= iw;
				last_addr_q <= instr_addr;
			end else if (dec_ready) begin
				dec_valid <= 1'b0;
			end
		end
	end

	// APB slave: read data captured in setup, so no wait states
	wire apb_setup = psel & ~penable;
	wire apb_wr = psel & penable & pwrite;
	reg addr_ok;
	reg [31:0] rd_d;

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	always @* begin
		addr_ok = 1'b1;
		rd_d = 32'h00000000;
		if (paddr == `IFD_REG_CTRL) begin
			rd_d[`IFD_CTRL_EN_BIT] = ctrl_en_q;
		end else if (paddr == `IFD_REG_LAST_WORD) begin
			rd_d = {last_addr_q, last_word_q};
		end else if (paddr == `IFD_REG_LAST_INFO) begin
			rd_d[10:0] = fmt;
			rd_d[`IFD_INFO_ILL_BIT] = illegal;
			rd_d[`IFD_INFO_EXT_LSB+1:`IFD_INFO_EXT_LSB] = ext_words;
			rd_d[`IFD_INFO_WIDTH_BIT] = width_select;
			rd_d[`IFD_INFO_CTX_BIT] = ctx_reload;
		end else if (paddr == `IFD_REG_LAST_TARGET) begin
			rd_d = {4'h0, line_addr, jump_target};
		end else if (paddr == `IFD_REG_LAST_COUNT) begin
			rd_d = {18'h00000, xop_num, tally, shift_count};
		end else if (paddr == `IFD_REG_ILLEGAL_CNT) begin
			rd_d = {16'h0000, ill_cnt_q};
		end else begin
			addr_ok = 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			ctrl_en_q <= `IFD_CTRL_RST;
			ill_cnt_q <= `IFD_CNT_RST;
		end else begin
			if (apb_setup) begin
				prdata <= rd_d;
			end
			if (apb_wr && paddr == `IFD_REG_CTRL) begin
				ctrl_en_q <= pwdata[`IFD_CTRL_EN_BIT];
			end
			// A clear in the same cycle as a new illegal word leaves a count of one
			if (take && ill_d) begin
				if (apb_wr && paddr == `IFD_REG_ILLEGAL_CNT) begin
					ill_cnt_q <= 16'h0001;
				end else begin
					ill_cnt_q <= ill_cnt_q + 16'h0001;
				end
			end else if (apb_wr && paddr == `IFD_REG_ILLEGAL_CNT) begin
				ill_cnt_q <= `IFD_CNT_RST;
			end
		end
	end

endmodule

// ==== ifd_consts.vh ====
// Constants of the instruction format decoder: register offsets, reset
// values, format flag positions, field codes and counts.
// Assumes inclusion by its bare name from the decoder module.
`ifndef IFD_CONSTS_VH
`define IFD_CONSTS_VH

// Register byte offsets on the APB side
`define IFD_REG_CTRL 8'h00
`define IFD_REG_LAST_WORD 8'h04
`define IFD_REG_LAST_INFO 8'h08
`define IFD_REG_LAST_TARGET 8'h0c
`define IFD_REG_LAST_COUNT 8'h10
`define IFD_REG_ILLEGAL_CNT 8'h14

// Reset values
`define IFD_CTRL_RST 1'b1
`define IFD_CNT_RST 16'h0000

// Control register fields
`define IFD_CTRL_EN_BIT 0

// Positions in the format flag vector: at most one of bits 0..9 set, width select in bit 10
`define IFD_F_TWO 0
`define IFD_F_JUMP 1
`define IFD_F_BIT 2
`define IFD_F_LOGIC 3
`define IFD_F_MULTI 4
`define IFD_F_SHIFT 5
`define IFD_F_SINGLE 6
`define IFD_F_CTRL 7
`define IFD_F_IMM 8
`define IFD_F_XOP 9
`define IFD_F_WIDTH 10

// Info register fields
`define IFD_INFO_ILL_BIT 10
`define IFD_INFO_EXT_LSB 11
`define IFD_INFO_WIDTH_BIT 13
`define IFD_INFO_CTX_BIT 14

// Mode codes
`define IFD_MODE_DIRECT 2'h0
`define IFD_MODE_MEM 2'h2
`define IFD_MODE_AUTO 2'h3

// Operation codes that steer decoding
`define IFD_OP_JUMP_LO 8'h10
`define IFD_OP_JUMP_HI 8'h1c
`define IFD_OP_BIT_HI 8'h1f
`define IFD_OP_XOP 6'h0b
`define IFD_OP_LOAD_LINES 6'h0c
`define IFD_OP_STORE_LINES 6'h0d
`define IFD_OP_CTRL_LO 11'h01a
`define IFD_OP_CTRL_HI 11'h01f
`define IFD_OP_IMM_LO 11'h010
`define IFD_OP_IMM_HI 11'h018
`define IFD_OP_STWP 11'h015
`define IFD_OP_STST 11'h016
`define IFD_OP_LWPI 11'h017
`define IFD_OP_LIMI 11'h018
`define IFD_OP_RET_CTX 11'h01c

// Context reload sources
`define IFD_CTX_WP_REG 4'hd
`define IFD_CTX_PC_REG 4'he
`define IFD_CTX_FLAG_REG 4'hf

// Counts
`define IFD_FULL_COUNT 5'h10
`define IFD_BYTE_MAX 5'h08
`define IFD_PC_STEP 16'h0002
`define IFD_STEP_BYTE 2'h1
`define IFD_STEP_WORD 2'h2

`endif

// ==== ifd_props.sv ====
// Checker for the instruction format decoder: decoded fields against the word taken.
// Assumes it is bound to the decoder and sees only the decoder's ports.
`timescale 1ns/1ps
module ifd_props (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Fetch side
	input wire instr_valid,
	input wire instr_ready,
	input wire [15:0] instr_word,
	input wire [15:0] instr_addr,
	input wire [15:0] wr0_val,
	input wire [15:0] wr12_val,
	// Decoded outputs
	input wire [10:0] fmt,
	input wire illegal,
	input wire [1:0] ext_words,
	input wire [10:0] op_field,
	input wire width_select,
	input wire ext_origin,
	input wire ext_target,
	input wire [1:0] origin_step,
	input wire [1:0] target_step,
	input wire [15:0] jump_target,
	input wire [11:0] line_addr,
	input wire [4:0] tally,
	input wire tally_byte,
	input wire [4:0] shift_count,
	input wire [3:0] xop_num,
	input wire ctx_reload,
	input wire [3:0] ctx_wp_reg,
	input wire [3:0] ctx_pc_reg,
	input wire [3:0] ctx_flag_reg
);
	wire tk = instr_valid && instr_ready;
	wire [15:0] w = instr_word;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Fields are judged one cycle after the take, against the word as it was taken
	ext_cnt_a: assert property (tk && w[15] |=> fmt[0] &&
		ext_words == ($past(w[11:10]) == 2'h2) + ($past(w[5:4]) == 2'h2))
		else $error("bad extension count");
	jmp_tgt_a: assert property (tk && w[15:8] >= 8'h10 && w[15:8] <= 8'h1c |=>
		fmt[1] && op_field == {3'h0, $past(w[15:8])} &&
		jump_target == $past(instr_addr) + 16'h2 + {{7{$past(w[7])}}, $past(w[7:0]), 1'b0})
		else $error("bad jump target");
	bit_line_a: assert property (tk && w[15:8] >= 8'h1d && w[15:8] <= 8'h1f |=>
		fmt[2] && line_addr == $past(wr12_val[12:1]) + {{4{$past(w[7])}}, $past(w[7:0])})
		else $error("bad line address");
	tally_a: assert property (tk && w[15:11] == 5'h06 |=>
		tally == ($past(w[9:6]) == 4'h0 ? 5'h10 : {1'b0, $past(w[9:6])}) &&
		tally_byte == (tally <= 5'h8) && line_addr == $past(wr12_val[12:1]))
		else $error("bad tally");
	shift_cnt_a: assert property (tk && w[15:10] == 6'h02 |=> shift_count ==
		($past(w[7:4]) != 0 ? {1'b0, $past(w[7:4])} : $past(wr0_val[3:0]) != 0 ? {1'b0, $past(wr0_val[3:0])} : 5'h10))
		else $error("bad shift count");
	xop_num_a: assert property (tk && w[15:10] == 6'h0b |=> fmt[9] && xop_num == $past(w[9:6]))
		else $error("bad extended op number");
	ctx_reg_a: assert property (tk && w == 16'h0380 |=> ctx_reload && fmt[7] &&
		ctx_wp_reg == 4'hd && ctx_pc_reg == 4'he && ctx_flag_reg == 4'hf)
		else $error("bad context reload");
	ill_word_a: assert property (tk && w[15:9] == 0 |=> illegal && fmt == 0)
		else $error("illegal word not flagged");
	op_fld_a: assert property (tk && w[15:13] >= 3'h2 |=>
		op_field == {8'h00, $past(w[15:13])} && width_select == $past(w[12]) && fmt[10] == $past(w[12]))
		else $error("bad two-address fields");
	ext_order_a: assert property (tk && w[15:13] >= 3'h2 |=>
		ext_origin == ($past(w[5:4]) == 2'h2) && ext_target == ($past(w[11:10]) == 2'h2))
		else $error("bad extension order");
	auto_step_a: assert property (tk && w[15:13] >= 3'h2 |=>
		origin_step == ($past(w[5:4]) == 2'h3 ? ($past(w[12]) ? 2'h1 : 2'h2) : 2'h0) &&
		target_step == ($past(w[11:10]) == 2'h3 ? ($past(w[12]) ? 2'h1 : 2'h2) : 2'h0))
		else $error("bad increment step");
endmodule

bind ifd_decoder ifd_props i_props (.*);

// ==== ifd_fetch_model.sv ====
// Fetch path and execution side stand-in: offers words, paces result acceptance.
// Assumes send is called just after a rising pclk edge.
`timescale 1ns/1ps
module ifd_fetch_model (
	// Clock and pacing
	input wire pclk,
	input wire slow,
	// Decoder handshake
	input wire instr_ready,
	output reg instr_valid = 0,
	output reg [15:0] instr_word = 0,
	output reg [15:0] instr_addr = 0,
	output reg [15:0] wr0_val = 0,
	output reg [15:0] wr12_val = 0,
	output reg dec_ready = 1
);
	// Word and workspace values held until the take edge
	task send(input [63:0] v);
		instr_valid <= 1'b1;
		{instr_word, instr_addr, wr0_val, wr12_val} <= v;
		@(posedge pclk);
		while (!instr_ready) @(posedge pclk);
	endtask
	// Released lines change, so a stale word is never mistaken for a valid one
	task idle;
		instr_valid <= 1'b0;
		instr_word <= ~instr_word;
	endtask
	always @(posedge pclk) dec_ready <= slow ? ~dec_ready : 1'b1;
endmodule

// ==== instr_format_decoder_test.sv ====
// Bench for the instruction format decoder: random words of each layout but control, which gets the fixed word 16'h0380, and APB access.
// Assumes the fetch model and the bound checker are compiled with it.
`timescale 1ns/1ps
module instr_format_decoder_test;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, er;
	reg [7:0] paddr = 0, d;
	reg [31:0] pwdata = 0, rd, seed, r;
	reg [15:0] w, a, wr0, wr12, sx, k;
	reg [9:0] fm;
	reg [4:0] t;
	reg [2:0] f;
	reg [28:0] e, q[$];
	integer i, n, err_total = 0, checks = 0;
	wire [31:0] prdata;
	wire pready, pslverr, instr_valid, instr_ready, dec_valid, dec_ready, illegal;
	wire width_select, tally_byte, lines_load, ctx_reload, ext_origin, ext_target;
	wire [1:0] target_mode, origin_mode, ext_words, origin_step, target_step;
	wire [3:0] target_reg_num, origin_reg_num, shifted_reg_num, xop_num;
	wire [3:0] ctx_wp_reg, ctx_pc_reg, ctx_flag_reg;
	wire [4:0] tally, shift_count;
	wire [10:0] fmt, op_field;
	wire [11:0] line_addr;
	wire [15:0] jump_target, instr_word, instr_addr, wr0_val, wr12_val;

	ifd_decoder i_dut (.*);
	ifd_fetch_model i_fm (.*);

	initial forever #12.5 pclk = ~pclk;

	task chk(input string nm, input [31:0] x, y);
		checks++;
		if (x !== y) begin
			err_total++;
			$display("MISMATCH %0s expected %h seen %h", nm, x, y);
		end
	endtask
	task apb(input wr, input [7:0] ad, input [31:0] wd);
		psel <= 1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk) penable <= 1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task stop_test;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function [15:0] key(input [2:0] fam);
		case (fam)
			0: key = {1'b0, ext_words, target_mode, target_reg_num, origin_mode, origin_reg_num, width_select};
			1: key = jump_target;
			2: key = line_addr;
			3: key = {tally_byte, lines_load, tally};
			4: key = {shifted_reg_num, shift_count};
			5: key = xop_num;
			6: key = ctx_reload;
			default: key = illegal;
		endcase
	endfunction

	// Each result is consumed at the edge where it is accepted
	always @(posedge pclk)
		if (presetn && dec_valid === 1'b1 && dec_ready === 1'b1) begin
			e = q.size() ? q.pop_front() : '1;
			chk("format", e[25:16], fmt[9:0]);
			chk("fields", e[15:0], key(e[28:26]));
		end

	initial begin
		#500000;
		err_total++;
		stop_test;
	end

	initial begin
		seed = 32'h5896;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, 8'h00, 0);
		chk("ctrl", 1, rd);
		apb(0, 8'h14, 0);
		chk("count", 0, rd);
		for (i = 0; i < 64; i++) begin
			r = $random(seed);
			{wr0, wr12} = $random(seed);
			a = r[31:16] & 16'hfffe;
			if (i[4]) wr0[3:0] = 0;
			if (i[3]) r[7:4] = 0;
			d = (i == 1) ? 8'h80 : (i == 9) ? 8'h7f : r[7:0];
			sx = {{8{d[7]}}, d};
			f = i[2:0];
			slow <= i[5];
			case (f)
				0: begin
					case (i[5:4])
						0: begin
							// Both memory modes first, then both auto-increment
							w = {1'b1, r[14:0]};
							{w[11:10], w[5:4]} = i[3] ? 4'hf : 4'ha;
							t = {4'h0, w[11:10] == 2'h2} + {4'h0, w[5:4] == 2'h2};
							k = {1'b0, t[1:0], w[11:0], w[12]};
							fm = 10'h001;
						end
						1: begin
							w = {5'h04, i[3], r[9:0]};
							k = {2'b00, w[5:4] == 2'h2, 2'h0, w[9:0], 1'b0};
							fm = 10'h008;
						end
						2: begin
							w = {6'h01, r[9:0]};
							k = {2'b00, w[5:4] == 2'h2, 6'h00, w[5:0], 1'b0};
							fm = 10'h040;
						end
						default: begin
							// One form with an operand word, one without
							w = {11'h010 + {i[3], 2'b01}, 1'b0, r[3:0]};
							k = {2'b00, ~i[3], 2'h0, w[3:0], 7'h00};
							fm = 10'h100;
						end
					endcase
				end
				1: begin
					w = {8'h10 + r[15:8] % 8'd13, d};
					k = a + 16'h2 + {sx[14:0], 1'b0};
				end
				2: begin
					w = {8'h1d + r[15:8] % 8'd3, d};
					k = {4'h0, wr12[12:1] + sx[11:0]};
				end
				3: begin
					w = {5'h06, r[10:0]};
					w[9:6] = {i[5:3], 1'b0} + 4'h8;
					t = (w[9:6] == 0) ? 5'h10 : {1'b0, w[9:6]};
					k = {t <= 5'h8, ~w[10], t};
				end
				4: begin
					w = {6'h02, r[9:0]};
					t = w[7:4] ? {1'b0, w[7:4]} : wr0[3:0] ? {1'b0, wr0[3:0]} : 5'h10;
					k = {w[3:0], t};
				end
				5: begin
					w = {6'h0b, r[9:0]};
					k = w[9:6];
				end
				6: begin
					w = 16'h0380;
					k = 1;
				end
				default: begin
					w = {7'h0, r[8:0]};
					k = 1;
				end
			endcase
			if (f != 0) begin
				fm = (f == 7) ? 10'h000 : 10'h1 << (f == 3 ? 4 : f == 4 ? 5 : f == 5 ? 9 : f == 6 ? 7 : f);
			end
			q.push_back({f, fm, k});
			i_fm.send({w, a, wr0, wr12});
		end
		i_fm.idle;
		for (n = 0; n < 100 && q.size() != 0; n++) @(posedge pclk);
		chk("drained", 0, q.size());
		apb(0, 8'h14, 0);
		chk("count", 8, rd);
		apb(1, 8'h14, 0);
		apb(0, 8'h14, 0);
		chk("cleared", 0, rd);
		apb(0, 8'h20, 0);
		chk("slverr", 1, er);
		chk("unmapped", 0, rd);
		apb(1, 8'h00, 0);
		chk("fetch off", 0, instr_ready);
		apb(0, 8'h00, 0);
		chk("ctrl", 0, rd);
		apb(1, 8'h00, 1);
		stop_test;
	end
endmodule
